/* bkr_control_regs.sv */
// regulator core control register bank behind a serial two-wire target port
`timescale 1ns/1ps
`include "bkr_defs.svh"

module bkr_control_regs
    import bkr_pkg::*;
#(
    parameter int PHASES = 4,
    parameter logic [1:0] PART_CODE = 2'h2, // arbitrary value
    parameter logic [1:0] LAYER_VERSION = 2'h1, // arbitrary value
    parameter logic [3:0] METAL_SPIN = 4'h3, // arbitrary value
    parameter logic [7:0] NV_VERSION = 8'h5A // arbitrary value
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaDrive_n,
    input wire logic firstEnablePin,
    input wire logic secondEnablePin,
    output logic coreOn,
    output logic roofSelect,
    output logic dischargeOn,
    output logic pwmForced,
    output logic multiphaseForced,
    output logic [2:0] forcedPhaseCount,
    output logic [2:0] currentLimitCode,
    output logic [2:0] rampRateCode
);

    if (PHASES < 2 || PHASES > 4)
    begin : g_bad_phases
        $error("bkr_control_regs supports 2 to 4 phases");
    end

    // true when the index selects the given offset
    function automatic logic regHit(input bkr_byte_t idx, input bkr_byte_t ofs);
        regHit = (idx == ofs);
    endfunction : regHit

    bkr_state_e state_r;
    bkr_state_e state_nxt;
    logic sdaLow_r;
    logic sdaLow_nxt;
    bkr_byte_t index_r;
    bkr_byte_t index_nxt;
    bkr_byte_t tx_r;
    bkr_byte_t tx_nxt;
    logic rw_r;
    logic rw_nxt;
    logic hostAck_r;
    bkr_byte_t primary_r;
    bkr_byte_t limits_r;
    logic clearBits;
    logic wrEn;
    logic startSeen;
    logic stopSeen;
    logic sclRise;
    logic sclFall;
    bkr_byte_t rxByte;
    logic rxFull;

    ////////////////////////////////////////////////////////////////////////////
    // line watcher and byte shifter
    bkr_bus_sampler #(
        .BITS(`BKR_BYTE_BITS)
    ) u_sampler (
        .clock(clock),
        .reset_n(reset_n),
        .ce(ce),
        .scl(scl),
        .sdaIn(sdaIn),
        .clearBits(clearBits),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .rxByte(rxByte),
        .rxFull(rxFull)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode and read selection
    wire addrHit = (rxByte[7:1] == `BKR_TARGET_ADDR);
    wire bkr_byte_t siliconRev = {PART_CODE, LAYER_VERSION, METAL_SPIN};
    wire bkr_byte_t readByte =
        regHit(index_r, `BKR_OFS_SILICON_REV) ? siliconRev :
        regHit(index_r, `BKR_OFS_NV_REV) ? NV_VERSION :
        regHit(index_r, `BKR_OFS_CORE0_PRIMARY) ? primary_r :
        regHit(index_r, `BKR_OFS_CORE0_LIMITS) ? limits_r : 8'h00;
    wire wrPrimary = wrEn & regHit(index_r, `BKR_OFS_CORE0_PRIMARY);
    wire wrLimits = wrEn & regHit(index_r, `BKR_OFS_CORE0_LIMITS);

    // control fields of the first core
    wire onBit = primary_r[`BKR_BIT_REGULATOR_ON];
    wire pinGating = primary_r[`BKR_BIT_PIN_GATING];
    wire pinChoice = primary_r[`BKR_BIT_GATE_PIN_CHOICE];
    wire roofFloor = primary_r[`BKR_BIT_ROOF_FLOOR];
    wire dischargeBit = primary_r[`BKR_BIT_DISCHARGE];
    wire pwmBit = primary_r[`BKR_BIT_FORCED_PWM];
    wire mpBit = primary_r[`BKR_BIT_FORCED_MULTIPHASE];
    wire [2:0] limitField = limits_r[`BKR_ILIM_MSB:`BKR_ILIM_LSB];
    wire [2:0] slewField = limits_r[`BKR_SLEW_MSB:`BKR_SLEW_LSB];

    // effective core behaviour from bits and pins
    wire selPin = pinChoice ? secondEnablePin : firstEnablePin;
    wire coreOn_nxt = onBit & (~pinGating | roofFloor | selPin);
    wire roof_nxt = ~(pinGating & roofFloor) | selPin;
    wire discharge_nxt = dischargeBit & ~coreOn_nxt;
    wire pwm_nxt = pwmBit | mpBit;
    wire [2:0] phases_nxt = mpBit ? 3'(PHASES) : 3'h0;

    assign sdaOut = 1'b0;
    assign sdaDrive_n = ~sdaLow_r;

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer, acts on falling clock edges
    always_comb
    begin
        state_nxt = state_r;
        sdaLow_nxt = sdaLow_r;
        index_nxt = index_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        clearBits = 1'b0;
        wrEn = 1'b0;
        if (stopSeen)
        begin
            state_nxt = S_IDLE;
            sdaLow_nxt = 1'b0;
        end
        else if (startSeen)
        begin
            state_nxt = S_ADDR;
            sdaLow_nxt = 1'b0;
        end
        else if (sclFall)
        begin
            unique case (state_r)
                S_IDLE: state_nxt = S_IDLE;
                S_ADDR:
                    if (rxFull)
                    begin
                        sdaLow_nxt = addrHit;
                        rw_nxt = rxByte[0];
                        state_nxt = addrHit ? S_ADDR_ACK : S_IDLE;
                    end
                S_ADDR_ACK:
                begin
                    clearBits = 1'b1;
                    if (rw_r)
                    begin
                        tx_nxt = readByte;
                        sdaLow_nxt = ~readByte[7];
                        state_nxt = S_RDATA;
                    end
                    else
                    begin
                        sdaLow_nxt = 1'b0;
                        state_nxt = S_REG;
                    end
                end
                S_REG:
                    if (rxFull)
                    begin
                        index_nxt = rxByte;
                        sdaLow_nxt = 1'b1;
                        state_nxt = S_REG_ACK;
                    end
                S_REG_ACK, S_WDATA_ACK:
                begin
                    clearBits = 1'b1;
                    sdaLow_nxt = 1'b0;
                    state_nxt = S_WDATA;
                end
                S_WDATA:
                    if (rxFull)
                    begin
                        wrEn = 1'b1;
                        index_nxt = index_r + 8'h01;
                        sdaLow_nxt = 1'b1;
                        state_nxt = S_WDATA_ACK;
                    end
                S_RDATA:
                    if (rxFull)
                    begin
                        sdaLow_nxt = 1'b0;
                        state_nxt = S_RACK;
                    end
                    else
                    begin
                        sdaLow_nxt = ~tx_r[6];
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                S_RACK:
                begin
                    clearBits = 1'b1;
                    tx_nxt = readByte;
                    sdaLow_nxt = hostAck_r & ~readByte[7];
                    state_nxt = hostAck_r ? S_RDATA : S_IDLE;
                end
                default: state_nxt = S_IDLE;
            endcase
        end
    end

    // sequencer state
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= S_IDLE;
            sdaLow_r <= 1'b0;
            index_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            sdaLow_r <= sdaLow_nxt;
            index_r <= index_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
        end
    end

    // host acknowledge after each read byte
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            hostAck_r <= 1'b0;
        else if (ce && sclRise && state_r == S_RACK)
            hostAck_r <= ~sdaIn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable control registers, whole byte kept
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            primary_r <= `BKR_RST_CORE0_PRIMARY;
            limits_r <= `BKR_RST_CORE0_LIMITS;
        end
        else if (ce)
        begin
            if (wrPrimary)
                primary_r <= rxByte;
            if (wrLimits)
                limits_r <= rxByte;
        end
    end

    // registered core control outputs
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            coreOn <= 1'b0;
            roofSelect <= 1'b1;
            dischargeOn <= 1'b1;
            pwmForced <= 1'b0;
            multiphaseForced <= 1'b0;
            forcedPhaseCount <= 3'h0;
            currentLimitCode <= 3'h7;
            rampRateCode <= 3'h2;
        end
        else if (ce)
        begin
            coreOn <= coreOn_nxt;
            roofSelect <= roof_nxt;
            dischargeOn <= discharge_nxt;
            pwmForced <= pwm_nxt;
            multiphaseForced <= mpBit;
            forcedPhaseCount <= phases_nxt;
            currentLimitCode <= limitField;
            rampRateCode <= slewField;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on the control outputs and the sequencer
    a_core_off_bit: assert property (@(posedge clock) disable iff (!reset_n)
        ce && !onBit |=> !coreOn)
        else $error("core on while on bit clear");

    a_pin_gate_and: assert property (@(posedge clock) disable iff (!reset_n)
        ce && onBit && pinGating && !roofFloor && !selPin |=> !coreOn)
        else $error("gated core on with pin low");

    a_pin_choice_second: assert property (@(posedge clock) disable iff (!reset_n)
        ce && onBit && pinGating && !roofFloor && pinChoice |=> coreOn == $past(secondEnablePin))
        else $error("second pin does not gate core");

    a_roof_floor_level: assert property (@(posedge clock) disable iff (!reset_n)
        ce && onBit && pinGating && roofFloor |=> coreOn && roofSelect == $past(selPin))
        else $error("roof floor selection wrong");

    a_discharge_when_off: assert property (@(posedge clock) disable iff (!reset_n)
        ce |=> dischargeOn == ($past(dischargeBit) && !coreOn))
        else $error("discharge resistor state wrong");

    a_multiphase_forced: assert property (@(posedge clock) disable iff (!reset_n)
        ce && mpBit |=> pwmForced && forcedPhaseCount == 3'(PHASES))
        else $error("multiphase does not force pwm");

    a_limit_follows: assert property (@(posedge clock) disable iff (!reset_n)
        ce && wrLimits ##1 ce |=> currentLimitCode == $past(rxByte[`BKR_ILIM_MSB:`BKR_ILIM_LSB], 2))
        else $error("current limit not applied");

    a_id_read_value: assert property (@(posedge clock) disable iff (!reset_n)
        ce && sclFall && state_r == S_ADDR_ACK && rw_r && index_r == `BKR_OFS_NV_REV
        |=> tx_r == NV_VERSION)
        else $error("revision read wrong");

    a_write_index_step: assert property (@(posedge clock) disable iff (!reset_n)
        ce && wrEn |=> index_r == 8'($past(index_r) + 8'h01) && sdaLow_r)
        else $error("write index did not advance");

    a_read_index_hold: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == S_RDATA && !startSeen |=> index_r == $past(index_r))
        else $error("read advanced index");

    a_addr_ack: assert property (@(posedge clock) disable iff (!reset_n)
        ce && state_r == S_ADDR && rxFull && sclFall && !startSeen && !stopSeen && addrHit
        |=> sdaLow_r && state_r == S_ADDR_ACK)
        else $error("address not acknowledged");

    a_stop_release: assert property (@(posedge clock) disable iff (!reset_n)
        ce && stopSeen |=> !sdaLow_r && state_r == S_IDLE)
        else $error("stop did not release data line");

endmodule : bkr_control_regs

/* bkr_defs.svh */
// register map, field positions, reset values and bus address of the regulator control bank
`ifndef BKR_DEFS_SVH
`define BKR_DEFS_SVH

`define BKR_TARGET_ADDR 7'h60
`define BKR_OFS_SILICON_REV 8'h00
`define BKR_OFS_NV_REV 8'h01
`define BKR_OFS_CORE0_PRIMARY 8'h02
`define BKR_OFS_CORE0_LIMITS 8'h03

`define BKR_BIT_REGULATOR_ON 7
`define BKR_BIT_PIN_GATING 6
`define BKR_BIT_GATE_PIN_CHOICE 5
`define BKR_BIT_ROOF_FLOOR 4
`define BKR_BIT_DISCHARGE 3
`define BKR_BIT_FORCED_PWM 1
`define BKR_BIT_FORCED_MULTIPHASE 0

`define BKR_ILIM_MSB 5
`define BKR_ILIM_LSB 3
`define BKR_SLEW_MSB 2
`define BKR_SLEW_LSB 0

`define BKR_RST_CORE0_PRIMARY 8'hC8
`define BKR_RST_CORE0_LIMITS 8'h3A
`define BKR_BYTE_BITS 8

`endif

/* bkr_pkg.sv */
// types shared by the regulator control bank
package bkr_pkg;

    typedef logic [7:0] bkr_byte_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_ADDR_ACK = 4'h2,
        S_REG = 4'h3,
        S_REG_ACK = 4'h4,
        S_WDATA = 4'h5,
        S_WDATA_ACK = 4'h6,
        S_RDATA = 4'h7,
        S_RACK = 4'h8
    } bkr_state_e;

endpackage : bkr_pkg

/* bkr_bus_sampler.sv */
// serial bus line watcher: start/stop detection, clock edges and byte shifter
`timescale 1ns/1ps
`include "bkr_defs.svh"

module bkr_bus_sampler
    import bkr_pkg::*;
#(
    parameter int BITS = `BKR_BYTE_BITS
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic clearBits,
    output logic startSeen,
    output logic stopSeen,
    output logic sclRise,
    output logic sclFall,
    output bkr_byte_t rxByte,
    output logic rxFull
);

    if (BITS != 8)
    begin : g_bad_bits
        $error("bkr_bus_sampler serves 8-bit bytes only");
    end

    logic sclPrev_r;
    logic sdaPrev_r;
    logic [3:0] count_r;
    bkr_byte_t shift_r;

    ////////////////////////////////////////////////////////////////////////////
    // line events, from previous and present levels
    assign startSeen = sclPrev_r & scl & sdaPrev_r & ~sdaIn;
    assign stopSeen = sclPrev_r & scl & ~sdaPrev_r & sdaIn;
    assign sclRise = ~sclPrev_r & scl;
    assign sclFall = sclPrev_r & ~scl;
    assign rxFull = (count_r == 4'(BITS));
    assign rxByte = shift_r;

    ////////////////////////////////////////////////////////////////////////////
    // previous line levels, idle bus is high
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end
        else if (ce)
        begin
            sclPrev_r <= scl;
            sdaPrev_r <= sdaIn;
        end
    end

    // bit count and msb-first shift on rising clock
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_r <= 4'h0;
            shift_r <= 8'h00;
        end
        else if (ce)
        begin
            if (startSeen || clearBits)
            begin
                count_r <= 4'h0;
            end
            else if (sclRise && !rxFull)
            begin
                count_r <= count_r + 4'h1;
                shift_r <= {shift_r[6:0], sdaIn};
            end
        end
    end

endmodule : bkr_bus_sampler

/* bkr_host_model.sv */
// two-wire bus host model: start, stop and byte transfers with acknowledge
`timescale 1ns/1ps

module bkr_host_model (
    input wire logic clock,
    input wire logic sdaWire,
    output logic scl,
    output logic sda
);

    // clocks per scl phase, set by the bench for prompt or slow traffic
    int half = 3;

    // bus idles high at time zero
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // start or repeated start: data falls while clock is high
    task automatic bus_start();
        tick(1);
        sda <= 1'b1;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda <= 1'b0;
        tick(half);
        scl <= 1'b0;
    endtask : bus_start

    // stop: data rises while clock is high, line then left released
    task automatic bus_stop();
        tick(1);
        sda <= 1'b0;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda <= 1'b1;
        tick(half);
    endtask : bus_stop

    // one bit: data changes one clock after the fall, sampled at end of high phase
    task automatic xfer_bit(input logic b, output logic got);
        tick(1);
        sda <= b;
        tick(half);
        scl <= 1'b1;
        tick(half);
        got = sdaWire;
        scl <= 1'b0;
    endtask : xfer_bit

    // eight bits msb first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic lastBit, output logic [7:0] rx,
        output logic ninth);
        logic got;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(tx[i], got);
            rx[i] = got;
        end
        xfer_bit(lastBit, ninth);
    endtask : xfer_byte

endmodule : bkr_host_model

/* bkr_control_regs_bench.sv */
// self-checking bench of the regulator control bank driven by a two-wire host model
`timescale 1ns/1ps
`include "bkr_defs.svh"

module bkr_control_regs_bench import bkr_pkg::*;;

    localparam int PH = 3;
    localparam logic [1:0] PC = 2'h1; // arbitrary value
    localparam logic [1:0] LV = 2'h3; // arbitrary value
    localparam logic [3:0] MS = 4'h0; // arbitrary value
    localparam logic [7:0] NVV = 8'hA7; // arbitrary value
    localparam bkr_byte_t WADDR = {`BKR_TARGET_ADDR, 1'b0};
    localparam bkr_byte_t RADDR = {`BKR_TARGET_ADDR, 1'b1};

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic scl, sdaHost, sdaWire, sdaOut, sdaDrive_n;
    logic firstEnablePin = 1'b0;
    logic secondEnablePin = 1'b0;
    logic ceIn = 1'b1;
    logic [13:0] heldOuts;
    logic coreOn, roofSelect, dischargeOn, pwmForced, multiphaseForced;
    logic [2:0] forcedPhaseCount, currentLimitCode, rampRateCode;
    int fails = 0;
    int totalChecks = 0;
    int mem[4];
    bkr_byte_t wq[$];

    // free-running 50 MHz clock
    always #10 clock = ~clock;

    // pulled-up data line, wired-AND of host and device
    assign sdaWire = sdaHost & (sdaDrive_n | sdaOut);

    bkr_control_regs #(.PHASES(PH), .PART_CODE(PC), .LAYER_VERSION(LV), .METAL_SPIN(MS),
        .NV_VERSION(NVV)) dut_u (
        .clock(clock), .reset_n(reset_n), .ce(ceIn), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaDrive_n(sdaDrive_n), .firstEnablePin(firstEnablePin),
        .secondEnablePin(secondEnablePin), .coreOn(coreOn), .roofSelect(roofSelect),
        .dischargeOn(dischargeOn), .pwmForced(pwmForced), .multiphaseForced(multiphaseForced),
        .forcedPhaseCount(forcedPhaseCount), .currentLimitCode(currentLimitCode),
        .rampRateCode(rampRateCode));

    bkr_host_model hostU (.clock(clock), .sdaWire(sdaWire), .scl(scl), .sda(sdaHost));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // register contents as a read should return them
    function automatic logic [7:0] exp_read(input int a);
        case (a)
            0: return {PC, LV, MS};
            1: return NVV;
            2, 3: return mem[a][7:0];
            default: return 8'h00;
        endcase
    endfunction : exp_read

    // control outputs expected from the model registers and pins
    function automatic logic [13:0] exp_outs();
        int p = mem[2];
        int l = mem[3];
        int pin = p[5] ? secondEnablePin : firstEnablePin;
        int on = p[7] && (!p[6] || p[4] || pin);
        int roof = (p[6] && p[4]) ? pin : 1;
        return {on[0], roof[0], p[3] && !on, p[1] || p[0], p[0], p[0] ? 3'(PH) : 3'h0,
            l[5:3], l[2:0]};
    endfunction : exp_outs

    task automatic check_outs();
        tick(3);
        check({2'h0, coreOn, roofSelect, dischargeOn, pwmForced, multiphaseForced,
            forcedPhaseCount, currentLimitCode, rampRateCode}, {2'h0, exp_outs()});
    endtask : check_outs

    task automatic new_pins();
        @(posedge clock);
        firstEnablePin <= 1'($urandom);
        secondEnablePin <= 1'($urandom);
    endtask : new_pins

    // write the queued bytes from index at, updating the model as the device should
    task automatic reg_write(input bkr_byte_t addrByte, input bkr_byte_t at);
        bkr_byte_t rx;
        logic ack;
        int a = at;
        hostU.bus_start();
        hostU.xfer_byte(addrByte, 1'b1, rx, ack);
        check({15'h0, ack}, {15'h0, addrByte[7:1] != `BKR_TARGET_ADDR});
        if (ack === 1'b0)
        begin
            hostU.xfer_byte(at, 1'b1, rx, ack);
            check({15'h0, ack}, 16'h0);
            foreach (wq[i])
            begin
                hostU.xfer_byte(wq[i], 1'b1, rx, ack);
                check({15'h0, ack}, 16'h0);
                if (a == 2 || a == 3)
                    mem[a] = wq[i];
                a = (a + 1) % 256;
            end
        end
        hostU.bus_stop();
        wq.delete();
    endtask : reg_write

    // read n bytes from index at; every byte repeats the same register
    task automatic reg_read(input bkr_byte_t at, input int n);
        bkr_byte_t rx;
        logic ack;
        hostU.bus_start();
        hostU.xfer_byte(WADDR, 1'b1, rx, ack);
        hostU.xfer_byte(at, 1'b1, rx, ack);
        hostU.bus_start();
        hostU.xfer_byte(RADDR, 1'b1, rx, ack);
        check({15'h0, ack}, 16'h0);
        for (int k = 0; k < n; k++)
        begin
            hostU.xfer_byte(8'hFF, k == n - 1, rx, ack);
            check({8'h0, rx}, {8'h0, exp_read(at)});
        end
        hostU.bus_stop();
    endtask : reg_read

    // read straight after the address, at the index left by the last access
    task automatic cur_read(input bkr_byte_t at);
        bkr_byte_t rx;
        logic ack;
        hostU.bus_start();
        hostU.xfer_byte(RADDR, 1'b1, rx, ack);
        check({15'h0, ack}, 16'h0);
        hostU.xfer_byte(8'hFF, 1'b1, rx, ack);
        check({8'h0, rx}, {8'h0, exp_read(at)});
        hostU.bus_stop();
    endtask : cur_read

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clock);
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    end

    // main sequence
    initial
    begin
        void'($urandom(96447));
        mem[2] = 8'hC8;
        mem[3] = 8'h3A;
        tick(20);
        reset_n <= 1'b1;
        check_outs();
        foreach (mem[i])
            reg_read(8'(i), 2);
        reg_read(8'h10, 1);
        wq = '{8'h77, 8'h24, 8'hC5};
        reg_write(WADDR, 8'h01);
        cur_read(8'h04);
        reg_read(8'h01, 1);
        reg_read(8'h02, 2);
        reg_read(8'h03, 1);
        cur_read(8'h03);
        check_outs();
        wq = '{8'h00};
        reg_write(8'hC2, 8'h02);
        reg_read(8'h02, 1);
        wq = '{8'h00, 8'h00, 8'h00};
        reg_write(WADDR, 8'hFF);
        reg_read(8'h00, 1);
        for (int k = 0; k < 20; k++)
        begin
            hostU.half = 2 + k % 5;
            new_pins();
            wq.push_back(8'($urandom));
            wq.push_back(8'($urandom));
            reg_write(WADDR, 8'h02);
            check_outs();
            new_pins();
            check_outs();
            reg_read(8'h02, 1);
            reg_read(8'h03, 1);
        end
        // clock enable low holds every output while the pins move
        heldOuts = exp_outs();
        @(posedge clock);
        ceIn <= 1'b0;
        firstEnablePin <= ~firstEnablePin;
        secondEnablePin <= ~secondEnablePin;
        tick(3);
        check({2'h0, coreOn, roofSelect, dischargeOn, pwmForced, multiphaseForced,
            forcedPhaseCount, currentLimitCode, rampRateCode}, {2'h0, heldOuts});
        ceIn <= 1'b1;
        check_outs();
        // second reset in mid-run brings back defaults
        @(posedge clock);
        reset_n <= 1'b0;
        tick(3);
        reset_n <= 1'b1;
        mem[2] = 8'hC8;
        mem[3] = 8'h3A;
        check_outs();
        reg_read(8'h02, 1);
        reg_read(8'h03, 1);
        report_and_stop();
    end

endmodule : bkr_control_regs_bench
